//--- hdl/atpg_test_pattern_gen.sv
// Purpose: Converter test-pattern generator with its serial-port registers
// Assumes: clock is the encode clock; serial-port pins are asynchronous
// Notes:   Patterns replace both channels' samples ahead of the downconverters
//
// Overview of operation
// - Test mode replaces analog samples with pattern
// - Test-mode bit 4 or 5 reseeds PN
// - Ignore analog input; advance only per sample
// - I takes channel A, Q channel B
// - Fourth downconverter: I via bit 0, no Q
// - Code 0100 checkerboard 0x1555 / 0x2AAA
// - Code 0101 long PN, seed 0x3AFF
// - Code 0110 short PN, seed 0x0092
// - Code 0111 toggles 0x0000 / 0x3FFF
// - Code 1000 user patterns, repeat or single
// - Code 1111 ramp modulo 2^14
`timescale 1ns/1ns
module atpg_test_pattern_gen (
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 spi_sclk,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_sdio_in,
    output logic                      spi_sdio_out,
    output logic                      spi_sdio_oe,
    input  wire logic                 adc_valid,
    output logic                      adc_ready,
    input  wire logic [13:0]          adc_chan_a,
    input  wire logic [13:0]          adc_chan_b,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output atpg_pkg::atpg_sample_t    out_sample,
    output atpg_pkg::atpg_ddc_sel_t   ddc_sel
);

    typedef struct packed {
        logic [1:0]       sclk_sync;
        logic [1:0]       cs_n_sync;
        logic [1:0]       sdi_sync;
        logic             sclk_prev;
        logic [4:0]       bit_cnt;
        logic [23:0]      shift_in;
        logic [7:0]       shift_out;
        logic             sdo;
        logic             sdo_oe;
        logic [7:0]       config_reg;
        logic [3:0][7:0]  downconv_reg;
        logic [7:0]       test_mode;
        logic [7:0][7:0]  user_pat;
        logic [7:0]       serial_test;
        logic [7:0]       serial_test_ext;
        logic [22:0]      pn_long;
        logic [8:0]       pn_short;
        logic             phase;
        logic [13:0]      ramp;
        logic [2:0]       user_idx;
        logic [7:0]       ddc_i;
        logic [7:0]       ddc_q;
    } atpg_state_t;

    atpg_state_t             st;
    atpg_state_t             next_st;
    atpg_pkg::atpg_sample_t  buf_in;
    logic                    buf_in_ready;
    logic                    push;
    logic                    pattern_on;
    logic [13:0]             pattern_word;

    ////////////////////////////////////////////////////////////////////////////
    // Pseudorandom words: fourteen stream bits per sample, first bit as MSB
    // Seed LSB leaves first; each sample consumes the next fourteen bits
    // Whole word per clock costs an unrolled loop, but keeps one sample a cycle

    function automatic logic [36:0] pn_long_adv(input logic [22:0] s);
        logic [22:0] r;
        logic [13:0] w;
        r = s;
        w = '0;
        for (int i = 0; i < atpg_pkg::PN_WORD_BITS; i++) begin
            w = {w[12:0], r[0]};
            r = {r[0] ^ r[5], r[22:1]};
        end
        return {w, r};
    endfunction

    function automatic logic [22:0] pn_short_adv(input logic [8:0] s);
        logic [8:0]  r;
        logic [13:0] w;
        r = s;
        w = '0;
        for (int i = 0; i < atpg_pkg::PN_WORD_BITS; i++) begin
            w = {w[12:0], r[0]};
            r = {r[0] ^ r[4], r[8:1]};
        end
        return {w, r};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pattern selection

    logic [36:0] pn_long_res;
    logic [22:0] pn_short_res;
    logic [15:0] user_word;

    assign pn_long_res  = pn_long_adv(st.pn_long);
    assign pn_short_res = pn_short_adv(st.pn_short);
    // High byte sits at the second, even address of each pair
    assign user_word    = {st.user_pat[{st.user_idx[1:0], 1'b1}], st.user_pat[{st.user_idx[1:0], 1'b0}]};

    always_comb begin
        pattern_on   = 1'b1;
        pattern_word = atpg_pkg::WORD_MIDSCALE;
        case (st.test_mode[3:0])
            atpg_pkg::ATPG_MODE_MIDSCALE: pattern_word = atpg_pkg::WORD_MIDSCALE;
            atpg_pkg::ATPG_MODE_POS_FULL: pattern_word = atpg_pkg::WORD_POS_FULL;
            atpg_pkg::ATPG_MODE_NEG_FULL: pattern_word = atpg_pkg::WORD_NEG_FULL;
            atpg_pkg::ATPG_MODE_CHECKER: begin
                pattern_word = st.phase ? atpg_pkg::WORD_CHECKER_ODD : atpg_pkg::WORD_CHECKER_EVEN;
            end
            atpg_pkg::ATPG_MODE_PN_LONG:  pattern_word = pn_long_res[36:23];
            atpg_pkg::ATPG_MODE_PN_SHORT: pattern_word = pn_short_res[22:9];
            atpg_pkg::ATPG_MODE_TOGGLE: begin
                pattern_word = st.phase ? atpg_pkg::WORD_ALL_ONE : atpg_pkg::WORD_ALL_ZERO;
            end
            atpg_pkg::ATPG_MODE_USER: begin
                // Index past the last pattern only occurs in single mode
                pattern_word = (st.user_idx == atpg_pkg::USER_PATTERN_COUNT) ?
                               atpg_pkg::WORD_ALL_ZERO : user_word[15:2];
            end
            atpg_pkg::ATPG_MODE_RAMP:     pattern_word = st.ramp;
            default:                      pattern_on   = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample path

    always_comb begin
        buf_in.test_active = pattern_on;
        if (pattern_on) begin
            // Analog words are dropped entirely while a pattern runs
            buf_in.chan_a = pattern_word;
            buf_in.chan_b = pattern_word;
        end else begin
            buf_in.chan_a = adc_chan_a;
            buf_in.chan_b = adc_chan_b;
        end
    end

    // Converter stalls only while both entries are taken
    assign adc_ready = buf_in_ready;
    assign push      = adc_valid & buf_in_ready;

    atpg_pair_buffer #(
        .WIDTH ($bits(atpg_pkg::atpg_sample_t))
    ) u_buffer (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (adc_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_sample)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Serial port and register file

    // Frame: read flag, 15-bit address, 8-bit data, MSB first
    logic        sclk_rise;
    logic        sclk_fall;
    logic [23:0] shifted;
    logic [14:0] hdr_addr;
    logic [7:0]  read_data;
    logic        wr_strobe;
    logic [14:0] wr_addr;
    logic [7:0]  wr_data;
    logic        soft_reset;
    logic        mode_write;

    assign sclk_rise = st.sclk_sync[1] & ~st.sclk_prev;
    assign sclk_fall = ~st.sclk_sync[1] & st.sclk_prev;
    assign shifted   = {st.shift_in[22:0], st.sdi_sync[1]};
    assign hdr_addr  = shifted[14:0];
    assign wr_addr   = shifted[22:8];
    assign wr_data   = shifted[7:0];
    assign wr_strobe = sclk_rise & ~st.cs_n_sync[1] & (st.bit_cnt == atpg_pkg::SPI_FRAME_LAST) & ~shifted[23];
    // Either soft-reset bit suffices
    assign soft_reset = wr_strobe & (wr_addr == atpg_pkg::ADDR_CONFIG_SOFT_RESET) &
                        ((wr_data & atpg_pkg::SOFT_RESET_MASK) != 8'h00);
    assign mode_write = wr_strobe & (wr_addr == atpg_pkg::ADDR_CONVERTER_TEST_MODE);

    always_comb begin
        read_data = atpg_pkg::REG_RESET_VALUE;
        if (hdr_addr >= atpg_pkg::ADDR_USER_PATTERN_FIRST && hdr_addr <= atpg_pkg::ADDR_USER_PATTERN_LAST) begin
            read_data = st.user_pat[3'(hdr_addr - atpg_pkg::ADDR_USER_PATTERN_FIRST)];
        end else begin
            case (hdr_addr)
                atpg_pkg::ADDR_CONFIG_SOFT_RESET:   read_data = st.config_reg;
                atpg_pkg::ADDR_DOWNCONV0_TEST:      read_data = st.downconv_reg[0];
                atpg_pkg::ADDR_DOWNCONV1_TEST:      read_data = st.downconv_reg[1];
                atpg_pkg::ADDR_DOWNCONV2_TEST:      read_data = st.downconv_reg[2];
                atpg_pkg::ADDR_DOWNCONV3_TEST:      read_data = st.downconv_reg[3];
                atpg_pkg::ADDR_CONVERTER_TEST_MODE: read_data = st.test_mode;
                atpg_pkg::ADDR_SERIAL_OUT_TEST:     read_data = st.serial_test;
                atpg_pkg::ADDR_SERIAL_OUT_TEST_EXT: read_data = st.serial_test_ext;
                default:                            read_data = atpg_pkg::REG_RESET_VALUE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        // Two flops on every serial pin before logic reads it
        next_st.sclk_sync = {st.sclk_sync[0], spi_sclk};
        next_st.cs_n_sync = {st.cs_n_sync[0], spi_cs_n};
        next_st.sdi_sync  = {st.sdi_sync[0], spi_sdio_in};
        next_st.sclk_prev = st.sclk_sync[1];

        if (st.cs_n_sync[1]) begin
            next_st.bit_cnt = 5'h00;
            next_st.sdo_oe  = 1'b0;
        end else if (sclk_rise) begin
            next_st.shift_in = shifted;
            next_st.bit_cnt  = (st.bit_cnt == atpg_pkg::SPI_FRAME_LAST) ? 5'h00 : st.bit_cnt + 5'h01;
            if (st.bit_cnt == atpg_pkg::SPI_HEADER_BITS - 5'h01 && shifted[15]) begin
                next_st.shift_out = read_data;
                next_st.sdo_oe    = 1'b1;
            end
            if (st.bit_cnt == atpg_pkg::SPI_FRAME_LAST) begin
                next_st.sdo_oe = 1'b0;
            end
        end else if (sclk_fall && st.sdo_oe) begin
            // Launch on falling edge so the host samples a settled bit
            next_st.sdo       = st.shift_out[7];
            next_st.shift_out = {st.shift_out[6:0], 1'b0};
        end

        if (wr_strobe) begin
            if (wr_addr >= atpg_pkg::ADDR_USER_PATTERN_FIRST && wr_addr <= atpg_pkg::ADDR_USER_PATTERN_LAST) begin
                next_st.user_pat[3'(wr_addr - atpg_pkg::ADDR_USER_PATTERN_FIRST)] = wr_data;
            end
            case (wr_addr)
                atpg_pkg::ADDR_CONFIG_SOFT_RESET: begin
                    next_st.config_reg = wr_data & ~atpg_pkg::SOFT_RESET_MASK;
                end
                atpg_pkg::ADDR_DOWNCONV0_TEST:      next_st.downconv_reg[0]  = wr_data;
                atpg_pkg::ADDR_DOWNCONV1_TEST:      next_st.downconv_reg[1]  = wr_data;
                atpg_pkg::ADDR_DOWNCONV2_TEST:      next_st.downconv_reg[2]  = wr_data;
                atpg_pkg::ADDR_DOWNCONV3_TEST:      next_st.downconv_reg[3]  = wr_data;
                atpg_pkg::ADDR_CONVERTER_TEST_MODE: next_st.test_mode        = wr_data;
                atpg_pkg::ADDR_SERIAL_OUT_TEST:     next_st.serial_test      = wr_data;
                atpg_pkg::ADDR_SERIAL_OUT_TEST_EXT: next_st.serial_test_ext  = wr_data;
                default: ;
            endcase
        end

        // Generators step once per accepted sample, never on idle clocks
        if (push && pattern_on) begin
            next_st.pn_long  = pn_long_res[22:0];
            next_st.pn_short = pn_short_res[8:0];
            next_st.phase    = ~st.phase;
            next_st.ramp     = st.ramp + 14'h0001;
            if (st.user_idx == atpg_pkg::USER_PATTERN_COUNT - 3'h1) begin
                next_st.user_idx = st.test_mode[atpg_pkg::USER_SINGLE_BIT] ?
                                   atpg_pkg::USER_PATTERN_COUNT : 3'h0;
            end else if (st.user_idx != atpg_pkg::USER_PATTERN_COUNT) begin
                next_st.user_idx = st.user_idx + 3'h1;
            end
        end

        // A new mode starts its sequence from the first sample
        if (mode_write) begin
            next_st.pn_long  = atpg_pkg::PN_LONG_SEED;
            next_st.pn_short = atpg_pkg::PN_SHORT_SEED;
            next_st.phase    = 1'b0;
            next_st.ramp     = 14'h0000;
            next_st.user_idx = 3'h0;
        end

        // Held at seed while either reset bit stays set
        if (next_st.test_mode[atpg_pkg::PN_LONG_RESET_BIT] || next_st.test_mode[atpg_pkg::PN_SHORT_RESET_BIT]) begin
            next_st.pn_long  = atpg_pkg::PN_LONG_SEED;
            next_st.pn_short = atpg_pkg::PN_SHORT_SEED;
        end

        for (int k = 0; k < 4; k++) begin
            next_st.ddc_i[k] = pattern_on & next_st.downconv_reg[k][atpg_pkg::DC_I_TEST_BIT];
            next_st.ddc_q[k] = (k < 3) & pattern_on &
                               next_st.downconv_reg[k][atpg_pkg::DC_Q_TEST_BIT];
        end
        next_st.ddc_i[7:4] = 4'h0;
        next_st.ddc_q[7:4] = 4'h0;

        // Soft reset returns every register and generator to its reset value
        if (soft_reset) begin
            next_st.config_reg      = atpg_pkg::REG_RESET_VALUE;
            next_st.downconv_reg    = '0;
            next_st.test_mode       = atpg_pkg::REG_RESET_VALUE;
            next_st.user_pat        = '0;
            next_st.serial_test     = atpg_pkg::REG_RESET_VALUE;
            next_st.serial_test_ext = atpg_pkg::REG_RESET_VALUE;
            next_st.pn_long         = atpg_pkg::PN_LONG_SEED;
            next_st.pn_short        = atpg_pkg::PN_SHORT_SEED;
            next_st.phase           = 1'b0;
            next_st.ramp            = 14'h0000;
            next_st.user_idx        = 3'h0;
            next_st.ddc_i           = 8'h00;
            next_st.ddc_q           = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Select resets high so no false frame follows reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st           <= '0;
            st.cs_n_sync <= 2'b11;
            st.pn_long   <= atpg_pkg::PN_LONG_SEED;
            st.pn_short  <= atpg_pkg::PN_SHORT_SEED;
        end else begin
            st <= next_st;
        end
    end

    // Only four downconverters; upper select bits unused
    assign spi_sdio_out   = st.sdo;
    assign spi_sdio_oe    = st.sdo_oe;
    assign ddc_sel.i_test = st.ddc_i[3:0];
    assign ddc_sel.q_test = st.ddc_q[3:0];

endmodule

//--- hdl/atpg_pkg.sv
// Purpose: Shared constants and types for the converter test-pattern generator
// Assumes: 14-bit two's complement samples, byte-wide serial-port registers
// Notes:   Offsets are serial-port register addresses (15-bit address space)
package atpg_pkg;

    localparam int SAMPLE_W = 14;

    // Register addresses
    localparam logic [14:0] ADDR_CONFIG_SOFT_RESET   = 15'h0000;
    localparam logic [14:0] ADDR_DOWNCONV0_TEST      = 15'h0327;
    localparam logic [14:0] ADDR_DOWNCONV1_TEST      = 15'h0347;
    localparam logic [14:0] ADDR_DOWNCONV2_TEST      = 15'h0367;
    localparam logic [14:0] ADDR_DOWNCONV3_TEST      = 15'h0387;
    localparam logic [14:0] ADDR_CONVERTER_TEST_MODE = 15'h0550;
    localparam logic [14:0] ADDR_USER_PATTERN_FIRST  = 15'h0551;
    localparam logic [14:0] ADDR_USER_PATTERN_LAST   = 15'h0558;
    localparam logic [14:0] ADDR_SERIAL_OUT_TEST     = 15'h0573;
    localparam logic [14:0] ADDR_SERIAL_OUT_TEST_EXT = 15'h0574;

    // Reset values and field positions
    localparam logic [7:0] REG_RESET_VALUE     = 8'h00;
    localparam logic [7:0] SOFT_RESET_MASK     = 8'h81;
    localparam int         PN_LONG_RESET_BIT   = 4;
    localparam int         PN_SHORT_RESET_BIT  = 5;
    localparam int         USER_SINGLE_BIT     = 7;
    localparam int         DC_I_TEST_BIT       = 0;
    localparam int         DC_Q_TEST_BIT       = 2;

    // Serial port framing: read flag, 15 address bits, 8 data bits
    localparam logic [4:0] SPI_HEADER_BITS     = 5'h10;
    localparam logic [4:0] SPI_FRAME_LAST      = 5'h17;

    // Pattern words
    localparam logic [13:0] WORD_MIDSCALE      = 14'h0000;
    localparam logic [13:0] WORD_POS_FULL      = 14'h1FFF;
    localparam logic [13:0] WORD_NEG_FULL      = 14'h2000;
    localparam logic [13:0] WORD_CHECKER_EVEN  = 14'h1555;
    localparam logic [13:0] WORD_CHECKER_ODD   = 14'h2AAA;
    localparam logic [13:0] WORD_ALL_ZERO      = 14'h0000;
    localparam logic [13:0] WORD_ALL_ONE       = 14'h3FFF;
    localparam logic [22:0] PN_LONG_SEED       = 23'h00_3AFF;
    localparam logic [8:0]  PN_SHORT_SEED      = 9'h092;
    localparam int          PN_WORD_BITS       = 14;
    localparam logic [2:0]  USER_PATTERN_COUNT = 3'h4;

    typedef enum logic [3:0] {
        ATPG_MODE_OFF       = 4'h0,
        ATPG_MODE_MIDSCALE  = 4'h1,
        ATPG_MODE_POS_FULL  = 4'h2,
        ATPG_MODE_NEG_FULL  = 4'h3,
        ATPG_MODE_CHECKER   = 4'h4,
        ATPG_MODE_PN_LONG   = 4'h5,
        ATPG_MODE_PN_SHORT  = 4'h6,
        ATPG_MODE_TOGGLE    = 4'h7,
        ATPG_MODE_USER      = 4'h8,
        ATPG_MODE_RAMP      = 4'hF
    } atpg_mode_t;

    typedef struct packed {
        logic          test_active;
        logic [13:0]   chan_b;
        logic [13:0]   chan_a;
    } atpg_sample_t;

    typedef struct packed {
        logic [3:0]    i_test;
        logic [3:0]    q_test;
    } atpg_ddc_sel_t;

endpackage

//--- hdl/atpg_pair_buffer.sv
// Purpose: Two-entry buffer in the sample path so a receiver stall loses nothing
// Assumes: One clock, asynchronous active-high reset
// Notes:   Full after two words; in_ready drops and stalls the source
`timescale 1ns/1ns
module atpg_pair_buffer #(
    parameter int WIDTH = 29
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    // Refused at elaboration: a zero-width word carries nothing
    if (WIDTH < 1) begin : g_width_check
        $error("atpg_pair_buffer: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wr_ptr;
        logic                  rd_ptr;
        logic [1:0]            count;
    } atpg_buf_state_t;

    atpg_buf_state_t st;
    atpg_buf_state_t next_st;
    logic            push;
    logic            pop;

    assign in_ready  = (st.count != 2'd2);
    assign out_valid = (st.count != 2'd0);
    assign out_data  = st.mem[st.rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr         = ~st.wr_ptr;
        end
        if (pop) begin
            next_st.rd_ptr = ~st.rd_ptr;
        end
        if (push && !pop) begin
            next_st.count = st.count + 2'd1;
        end else if (pop && !push) begin
            next_st.count = st.count - 2'd1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

//--- verif/atpg_tpg_asserts.sv
// Purpose: Port-level checks of the test-pattern generator
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to the top module by name
`timescale 1ns/1ns
module atpg_tpg_asserts (
    input wire logic                    clock,
    input wire logic                    sys_rst,
    input wire logic                    spi_cs_n,
    input wire logic                    spi_sdio_oe,
    input wire logic                    adc_valid,
    input wire logic                    adc_ready,
    input wire logic                    out_valid,
    input wire logic                    out_ready,
    input wire atpg_pkg::atpg_sample_t  out_sample,
    input wire atpg_pkg::atpg_ddc_sel_t ddc_sel
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_take;  adc_valid && adc_ready;  endsequence
    sequence s_stall; out_valid && !out_ready; endsequence
    a_word_next: assert property (s_take ##0 !out_valid |=> out_valid)
        else $error("accepted sample not offered next cycle");
    a_stall_hold: assert property (s_stall |=> out_valid && $stable(out_sample))
        else $error("word changed while receiver stalled");
    a_full_stays: assert property (!adc_ready && !out_ready |=> !adc_ready)
        else $error("full buffer took a sample");
    a_empty_takes: assert property (!out_valid |-> adc_ready)
        else $error("empty buffer refused a sample");
    a_full_offers: assert property (!adc_ready |-> out_valid)
        else $error("refusing while holding nothing");
    a_pair_same: assert property (out_valid && out_sample.test_active |->
        out_sample.chan_a == out_sample.chan_b)
        else $error("channels carry different patterns");
    a_q3_never: assert property (ddc_sel.q_test[3] == 1'b0)
        else $error("fourth downconverter Q got a pattern");
    a_oe_quiet: assert property (spi_cs_n [*5] |-> !spi_sdio_oe)
        else $error("data line driven while deselected");
endmodule
////////////////////////////////////////////////////////////////////////////
bind atpg_test_pattern_gen atpg_tpg_asserts i_asserts (.clock(clock), .sys_rst(sys_rst),
    .spi_cs_n(spi_cs_n), .spi_sdio_oe(spi_sdio_oe), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample), .ddc_sel(ddc_sel));

//--- verif/atpg_rx_model.sv
// Purpose: Receiver at the far side of the sample stream
// Assumes: Same clock as the generator
// Notes:   Stall mode takes one word in four to fill the buffer
`timescale 1ns/1ns
module atpg_rx_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic stall,
    output logic     out_ready
);
    logic [1:0] phase;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase     <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            phase     <= phase + 2'h1;
            out_ready <= !stall || (phase == 2'h3);
        end
    end
endmodule

//--- verif/adc_test_pattern_gen_bench.sv
// Purpose: Self-checking bench for the test-pattern generator
// Assumes: Serial port clocked slowly, six encode clocks per half period
// Notes:   Receiver stalls during the t_patterns runs to exercise the buffer
`timescale 1ns/1ns
module adc_test_pattern_gen_bench;
    logic clock = 1'b0, sys_rst = 1'b1, stall = 1'b0;
    logic spi_sclk = 1'b0, spi_cs_n = 1'b1, spi_sdio_in = 1'b0;
    logic adc_valid = 1'b0, out_ready, spi_sdio_out, spi_sdio_oe, adc_ready, out_valid;
    logic [13:0] adc_chan_a = 14'h0123, adc_chan_b = 14'h0456;
    atpg_pkg::atpg_sample_t  out_sample;
    atpg_pkg::atpg_ddc_sel_t ddc_sel;
    atpg_pkg::atpg_sample_t  got_q [$];
    int n_mismatch = 0, cmp_count = 0;
    logic [15:0] up [4] = '{16'h1234, 16'hABCD, 16'h5678, 16'hFFFC};
    logic [13:0] tbl [7][3] = '{'{14'h0000, 14'h0000, 14'h0000}, '{14'h1FFF, 14'h1FFF, 14'h1FFF},
        '{14'h2000, 14'h2000, 14'h2000}, '{14'h1555, 14'h2AAA, 14'h1555},
        '{14'h3FD7, 14'h0002, 14'h26E0}, '{14'h125B, 14'h3C9A, 14'h2660},
        '{14'h0000, 14'h3FFF, 14'h0000}};
    always #2 clock = ~clock;
    atpg_test_pattern_gen i_dut (.clock(clock), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .adc_chan_a(adc_chan_a), .adc_chan_b(adc_chan_b), .out_valid(out_valid),
        .out_ready(out_ready), .out_sample(out_sample), .ddc_sel(ddc_sel));
    atpg_rx_model i_rx (.clock(clock), .sys_rst(sys_rst), .stall(stall), .out_ready(out_ready));
    always @(posedge clock) if (out_valid && out_ready) got_q.push_back(out_sample);
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Half period of six clocks keeps well above the four-clock minimum
    task automatic spi(input logic [23:0] fr, output logic [7:0] rdat);
        spi_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdio_in = fr[i];
            spi_sclk    = 1'b0;
            tick(6);
            if (i < 8) rdat[i] = spi_sdio_out;
            spi_sclk = 1'b1;
            tick(6);
        end
        spi_sclk = 1'b0;
        tick(6);
        spi_cs_n = 1'b1;
        tick(8);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] r;
        spi({1'b0, a, d}, r);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] r;
        spi({1'b1, a, 8'h00}, r);
        chk({6'h00, r}, {6'h00, e});
    endtask
    task automatic run(input logic [7:0] code, input int n);
        int k;
        wr(atpg_pkg::ADDR_CONVERTER_TEST_MODE, code);
        got_q.delete();
        adc_valid = 1'b1;
        for (k = 0; k < 400 && got_q.size() < n; k++) tick(1);
        adc_valid = 1'b0;
        tick(12);
        if (k == 400) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(atpg_pkg::ADDR_CONVERTER_TEST_MODE, 8'h00);
        wr(15'h0100, 8'hFF);
        rd(15'h0100, 8'h00);
        wr(atpg_pkg::ADDR_SERIAL_OUT_TEST, 8'h5A);
        rd(atpg_pkg::ADDR_SERIAL_OUT_TEST, 8'h5A);
    endtask
    task automatic t_patterns();
        stall = 1'b1;
        for (int m = 1; m < 8; m++) begin
            run(8'(m), 3);
            for (int k = 0; k < 3; k++) begin
                chk(got_q[k].chan_a, tbl[m-1][k]);
                chk(got_q[k].chan_b, tbl[m-1][k]);
                chk({13'h0000, got_q[k].test_active}, 14'h0001);
            end
        end
        run(8'h0F, 3);
        chk(got_q[1].chan_a, got_q[0].chan_a + 14'h0001);
        chk(got_q[2].chan_a, got_q[0].chan_a + 14'h0002);
        stall = 1'b0;
    endtask
    task automatic t_user();
        logic [13:0] e;
        for (int k = 0; k < 4; k++) begin
            wr(atpg_pkg::ADDR_USER_PATTERN_FIRST + 15'(2*k), up[k][7:0]);
            wr(atpg_pkg::ADDR_USER_PATTERN_FIRST + 15'(2*k+1), up[k][15:8]);
        end
        for (int s = 0; s < 2; s++) begin
            run(s ? 8'h88 : 8'h08, 5);
            for (int j = 0; j < 5; j++) begin
                e = (j < 4) ? up[j][15:2] : (s ? 14'h0000 : up[0][15:2]);
                chk(got_q[j].chan_a, e);
            end
        end
    endtask
    task automatic t_reseed();
        run(8'h16, 2);
        chk(got_q[0].chan_a, 14'h125B);
        chk(got_q[1].chan_a, 14'h125B);
    endtask
    task automatic t_ddc();
        wr(atpg_pkg::ADDR_DOWNCONV0_TEST, 8'h05);
        wr(atpg_pkg::ADDR_DOWNCONV3_TEST, 8'h05);
        run(8'h04, 1);
        chk({6'h00, ddc_sel}, 14'h0091);
        rd(atpg_pkg::ADDR_DOWNCONV3_TEST, 8'h05);
        run(8'h00, 1);
        chk(got_q[0].chan_a, 14'h0123);
        chk(got_q[0].chan_b, 14'h0456);
        chk({13'h0000, got_q[0].test_active}, 14'h0000);
    endtask
    task automatic t_soft();
        wr(atpg_pkg::ADDR_CONVERTER_TEST_MODE, 8'h04);
        wr(atpg_pkg::ADDR_CONFIG_SOFT_RESET, 8'h81);
        rd(atpg_pkg::ADDR_CONVERTER_TEST_MODE, 8'h00);
        rd(atpg_pkg::ADDR_CONFIG_SOFT_RESET, 8'h00);
        rd(atpg_pkg::ADDR_DOWNCONV0_TEST, 8'h00);
    endtask
    initial begin
        tick(6);
        sys_rst = 1'b0;
        tick(4);
        t_regs();
        t_patterns();
        t_user();
        t_reseed();
        t_ddc();
        t_soft();
        complete_run();
    end
endmodule
